// *** core/sdbt_defines.vh ***
`ifndef SDBT_DEFINES_VH
`define SDBT_DEFINES_VH

// clock and time base
`define SDBT_CLK_MHZ         200
`define SDBT_TICK_NS         1000
`define SDBT_TICK_CYCLES     ((`SDBT_TICK_NS * `SDBT_CLK_MHZ) / 1000)

// register byte offsets
`define SDBT_OFS_CTRL        8'h00
`define SDBT_OFS_STATUS      8'h04
`define SDBT_OFS_MASK        8'h08
`define SDBT_OFS_STATE       8'h0C

// control field positions
`define SDBT_CTRL_DIG_LSB    0
`define SDBT_CTRL_ANA_LSB    3
`define SDBT_CTRL_WIDTH_BIT  5
`define SDBT_CTRL_DUTY_LSB   6
`define SDBT_CTRL_BOOST_BIT  8
`define SDBT_CTRL_BITS       9
`define SDBT_CTRL_RESET      9'h000

// status and mask bits
`define SDBT_ST_ANA_FAULT    0
`define SDBT_ST_DIG_FAULT    1
`define SDBT_ST_BOOST_PER    2
`define SDBT_ST_BITS         3
`define SDBT_MASK_RESET      3'h0

// analog deglitch times in ns
`define SDBT_ANA_NS_0        0
`define SDBT_ANA_NS_1        200
`define SDBT_ANA_NS_2        500
`define SDBT_ANA_NS_3        1000

// digital deglitch times in us
`define SDBT_DIG_US_0        0
`define SDBT_DIG_US_1        10
`define SDBT_DIG_US_2        100
`define SDBT_DIG_US_3        1000
`define SDBT_DIG_US_4        10000
`define SDBT_DIG_US_5        100000
`define SDBT_DIG_US_6        500000
`define SDBT_DIG_US_7        1000000

// boost pulse on-time in us and duty in percent
`define SDBT_BOOST_ON_US_0   100
`define SDBT_BOOST_ON_US_1   1000
`define SDBT_DUTY_PCT_0      2
`define SDBT_DUTY_PCT_1      5
`define SDBT_DUTY_PCT_2      10
`define SDBT_DUTY_PCT_3      20

`endif

// *** core/sdbt_tick.v ***
`include "sdbt_defines.vh"

module sdbt_tick #(
   parameter TICK_CYCLES = `SDBT_TICK_CYCLES
) (
   // clock and reset
   input  wire clk,
   input  wire reset_n,
   // one-cycle pulse per time-base tick
   output reg  tick_q
);

   localparam [31:0] TICK_W = TICK_CYCLES;

   reg [15:0] cnt_q;

   always @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         cnt_q  <= 16'h0000;
         tick_q <= 1'b0;
      end
      else if (cnt_q >= TICK_W[15:0] - 16'h0001)
      begin
         cnt_q  <= 16'h0000;
         tick_q <= 1'b1;
      end
      else
      begin
         cnt_q  <= cnt_q + 16'h0001;
         tick_q <= 1'b0;
      end
   end

endmodule // sdbt_tick

// *** core/sdbt_short_boost.v ***
// What this block does
// - short fault declared after comparator stays high for 3-bit selected digital time
// - analog comparator path filtered by 2-bit selected 0/200/500/1000 ns deglitch
// - boost gate pulse on-time is 0.1 ms or 1.0 ms by one bit
// - boost duty cycle is 2, 5, 10 or 20 percent by 2-bit field
// - gate turn-off starts within 1 us after a fault is declared
//
// Added by the designer: register access over APB and the register offsets.
`include "sdbt_defines.vh"

module sdbt_short_boost #(
   parameter TICK_CYCLES = `SDBT_TICK_CYCLES
) (
   // clock and reset
   input  wire        clk,
   input  wire        reset_n,
   // apb slave
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [7:0]  paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   // comparator inputs from pins
   input  wire        short_analog_cmp,
   input  wire        short_digital_cmp,
   // gate driver side
   output reg         gate_off_q,
   output reg         boost_gate_q,
   // interrupt
   output reg         irq_q
);

   ////////////////////////////////////////////////////////////////////////
   // lookup functions

   function [7:0] ana_cycles;
      input [1:0]  sel;
      reg   [31:0] cyc;
      begin
         case (sel)
            2'h0:    cyc = (`SDBT_ANA_NS_0 * `SDBT_CLK_MHZ) / 1000;
            2'h1:    cyc = (`SDBT_ANA_NS_1 * `SDBT_CLK_MHZ) / 1000;
            2'h2:    cyc = (`SDBT_ANA_NS_2 * `SDBT_CLK_MHZ) / 1000;
            default: cyc = (`SDBT_ANA_NS_3 * `SDBT_CLK_MHZ) / 1000;
         endcase
         ana_cycles = cyc[7:0];
      end
   endfunction

   function [19:0] dig_ticks;
      input [2:0]  sel;
      reg   [31:0] us;
      begin
         case (sel)
            3'h0:    us = `SDBT_DIG_US_0;
            3'h1:    us = `SDBT_DIG_US_1;
            3'h2:    us = `SDBT_DIG_US_2;
            3'h3:    us = `SDBT_DIG_US_3;
            3'h4:    us = `SDBT_DIG_US_4;
            3'h5:    us = `SDBT_DIG_US_5;
            3'h6:    us = `SDBT_DIG_US_6;
            default: us = `SDBT_DIG_US_7;
         endcase
         dig_ticks = us[19:0];
      end
   endfunction

   function [15:0] on_ticks;
      input        sel;
      reg   [31:0] us;
      begin
         us = sel ? `SDBT_BOOST_ON_US_1 : `SDBT_BOOST_ON_US_0;
         on_ticks = us[15:0];
      end
   endfunction

   function [15:0] period_ticks;
      input       width_sel;
      input [1:0] duty_sel;
      reg   [31:0] on;
      reg   [31:0] pct;
      reg   [31:0] per;
      begin
         on = {16'h0000, on_ticks(width_sel)};
         case (duty_sel)
            2'h0:    pct = `SDBT_DUTY_PCT_0;
            2'h1:    pct = `SDBT_DUTY_PCT_1;
            2'h2:    pct = `SDBT_DUTY_PCT_2;
            default: pct = `SDBT_DUTY_PCT_3;
         endcase
         per = (on * 32'd100) / pct;
         period_ticks = per[15:0];
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // registers and time base

   reg  [`SDBT_CTRL_BITS-1:0] ctrl_q;
   reg  [`SDBT_ST_BITS-1:0]   status_q;
   reg  [`SDBT_ST_BITS-1:0]   mask_q;
   wire                       tick;

   wire [2:0] dig_sel    = ctrl_q[`SDBT_CTRL_DIG_LSB +: 3];
   wire [1:0] ana_sel    = ctrl_q[`SDBT_CTRL_ANA_LSB +: 2];
   wire       width_sel  = ctrl_q[`SDBT_CTRL_WIDTH_BIT];
   wire [1:0] duty_sel   = ctrl_q[`SDBT_CTRL_DUTY_LSB +: 2];
   wire       boost_en   = ctrl_q[`SDBT_CTRL_BOOST_BIT];

   sdbt_tick #(
      .TICK_CYCLES (TICK_CYCLES)
   ) u_tick (
      .clk     (clk),
      .reset_n (reset_n),
      .tick_q  (tick)
   );

   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers: change accepted when stages two and three agree

   reg [1:0] sync1_q;
   reg [1:0] sync2_q;
   reg [1:0] sync3_q;
   reg [1:0] cmp_q;

   always @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         sync1_q <= 2'h0;
         sync2_q <= 2'h0;
         sync3_q <= 2'h0;
         cmp_q   <= 2'h0;
      end
      else
      begin
         sync1_q <= {short_digital_cmp, short_analog_cmp};
         sync2_q <= sync1_q;
         sync3_q <= sync2_q;
         cmp_q   <= (sync2_q & sync3_q) | (cmp_q & (sync2_q | sync3_q));
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // short fault deglitch paths

   reg  [7:0]  ana_cnt_q;
   reg  [19:0] dig_cnt_q;
   wire [7:0]  ana_target = ana_cycles(ana_sel);
   wire [19:0] dig_target = dig_ticks(dig_sel);
   wire        ana_hit    = cmp_q[0] & (ana_cnt_q >= ana_target);
   wire        dig_hit    = cmp_q[1] & (dig_cnt_q >= dig_target);

   always @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         ana_cnt_q <= 8'h00;
         dig_cnt_q <= 20'h00000;
      end
      else
      begin
         if (!cmp_q[0])
            ana_cnt_q <= 8'h00;
         else if (ana_cnt_q != 8'hFF)
            ana_cnt_q <= ana_cnt_q + 8'h01;
         if (!cmp_q[1])
            dig_cnt_q <= 20'h00000;
         else if (tick && dig_cnt_q != 20'hFFFFF)
            dig_cnt_q <= dig_cnt_q + 20'h00001;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // boost pulse generator

   reg  [15:0] boost_cnt_q;
   wire [15:0] on_len     = on_ticks(width_sel);
   wire [15:0] per_len    = period_ticks(width_sel, duty_sel);
   wire        boost_run  = boost_en & ~gate_off_q;
   wire        per_wrap   = boost_run & tick & (boost_cnt_q >= per_len - 16'h0001);

   always @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         boost_cnt_q  <= 16'h0000;
         boost_gate_q <= 1'b0;
      end
      else if (!boost_run)
      begin
         boost_cnt_q  <= 16'h0000;
         boost_gate_q <= 1'b0;
      end
      else
      begin
         if (per_wrap)
            boost_cnt_q <= 16'h0000;
         else if (tick)
            boost_cnt_q <= boost_cnt_q + 16'h0001;
         boost_gate_q <= (boost_cnt_q < on_len);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // apb slave, status and interrupt

   wire        setup    = psel & ~penable;
   wire        commit   = psel & penable & pready;
   wire        wr       = commit & pwrite;
   wire        mapped   = (paddr == `SDBT_OFS_CTRL) | (paddr == `SDBT_OFS_STATUS) |
                          (paddr == `SDBT_OFS_MASK) | (paddr == `SDBT_OFS_STATE);
   wire [`SDBT_ST_BITS-1:0] events = {per_wrap, dig_hit, ana_hit};
   reg  [`SDBT_ST_BITS-1:0] clr;
   reg  [`SDBT_ST_BITS-1:0] status_d;
   reg  [31:0]              rdata;

   always @*
   begin
      clr = (wr && paddr == `SDBT_OFS_STATUS) ? pwdata[`SDBT_ST_BITS-1:0] : {`SDBT_ST_BITS{1'b0}};
      // set wins over clear
      status_d = (status_q & ~clr) | events;
      case (paddr)
         `SDBT_OFS_CTRL:   rdata = {{(32-`SDBT_CTRL_BITS){1'b0}}, ctrl_q};
         `SDBT_OFS_STATUS: rdata = {{(32-`SDBT_ST_BITS){1'b0}}, status_q};
         `SDBT_OFS_MASK:   rdata = {{(32-`SDBT_ST_BITS){1'b0}}, mask_q};
         `SDBT_OFS_STATE:  rdata = {28'h0000000, boost_gate_q, gate_off_q, cmp_q};
         default:          rdata = 32'h00000000;
      endcase
   end

   always @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         ctrl_q     <= `SDBT_CTRL_RESET;
         mask_q     <= `SDBT_MASK_RESET;
         status_q   <= {`SDBT_ST_BITS{1'b0}};
         gate_off_q <= 1'b0;
         irq_q      <= 1'b0;
         pready     <= 1'b0;
         pslverr    <= 1'b0;
         prdata     <= 32'h00000000;
      end
      else
      begin
         pready  <= setup;
         pslverr <= setup & ~mapped;
         prdata  <= (setup && !pwrite) ? rdata : 32'h00000000;
         if (wr && paddr == `SDBT_OFS_CTRL)
            ctrl_q <= pwdata[`SDBT_CTRL_BITS-1:0];
         if (wr && paddr == `SDBT_OFS_MASK)
            mask_q <= pwdata[`SDBT_ST_BITS-1:0];
         status_q <= status_d;
         // gate off one cycle after fault
         gate_off_q <= status_d[`SDBT_ST_ANA_FAULT] | status_d[`SDBT_ST_DIG_FAULT];
         irq_q      <= |(status_d & mask_q);
      end
   end

endmodule // sdbt_short_boost

// *** test/sdbt_chk.sv ***
module sdbt_chk #(
   parameter TICK_CYCLES = 2
) (
   // clock and reset
   input wire        clk,
   input wire        reset_n,
   // apb
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   input wire [7:0]  paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire        pready,
   input wire        pslverr,
   // pins
   input wire        short_analog_cmp,
   input wire        short_digital_cmp,
   input wire        gate_off_q,
   input wire        boost_gate_q,
   input wire        irq_q
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   localparam int T = TICK_CYCLES;
   reg [8:0]  ctrl_q;
   reg [15:0] hi_q;
   reg [15:0] lo_q;
   reg        fell_q;
   int        on_c;
   int        off_c;
   always @*
   begin
      on_c = (ctrl_q[5] ? 1000 : 100) * T;
      off_c = on_c * 100 / (ctrl_q[7:6] == 2'h0 ? 2 : ctrl_q[7:6] == 2'h1 ? 5 : ctrl_q[7:6] == 2'h2 ? 10 : 20) - on_c;
   end
   // shadow of ctrl and boost phase lengths
   always @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         ctrl_q <= 9'h000;
         hi_q <= 16'h0000;
         lo_q <= 16'h0000;
         fell_q <= 1'b0;
      end
      else
      begin
         if (psel && penable && pready && pwrite && paddr == 8'h00)
            ctrl_q <= pwdata[8:0];
         hi_q <= boost_gate_q ? hi_q + 16'h0001 : 16'h0000;
         lo_q <= boost_gate_q ? 16'h0000 : lo_q + 16'h0001;
         fell_q <= ctrl_q[8] && !gate_off_q && (fell_q || $fell(boost_gate_q));
      end
   end
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_access;
      psel && penable;
   endsequence
   chk_apb_zero_wait: assert property (s_setup |=> s_access ##0 pready)
      else $error("pready missing after setup");
   chk_ready_in_access: assert property (pready |-> s_access)
      else $error("pready outside access");
   chk_err_unmapped: assert property (pready |-> pslverr == !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0C}))
      else $error("pslverr wrong for address");
   chk_ana_fast_path: assert property ((ctrl_q[4:3] == 2'h0 && short_analog_cmp) [*7] |-> gate_off_q)
      else $error("analog fault not declared");
   chk_fault_has_cause: assert property ($rose(gate_off_q) |-> $past(short_analog_cmp, 2) || $past(short_digital_cmp, 2))
      else $error("fault without comparator");
   chk_off_kills_boost: assert property (gate_off_q |=> !boost_gate_q)
      else $error("boost pulse during fault");
   chk_boost_on_time: assert property ($fell(boost_gate_q) && ctrl_q[8] && !gate_off_q |-> hi_q >= on_c - T - 2 && hi_q <= on_c + T + 2)
      else $error("boost on-time wrong");
   chk_boost_off_time: assert property ($rose(boost_gate_q) && fell_q && ctrl_q[8] |-> lo_q >= off_c - T - 2 && lo_q <= off_c + T + 2)
      else $error("boost off-time wrong");
endmodule // sdbt_chk

bind sdbt_short_boost sdbt_chk #(.TICK_CYCLES(TICK_CYCLES)) u_chk (.clk(clk), .reset_n(reset_n), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .short_analog_cmp(short_analog_cmp), .short_digital_cmp(short_digital_cmp),
   .gate_off_q(gate_off_q), .boost_gate_q(boost_gate_q), .irq_q(irq_q));

// *** test/sdbt_gate_model.sv ***
module sdbt_gate_model (
   // clock and reset
   input  wire        clk,
   input  wire        reset_n,
   // commands from the block
   input  wire        gate_off_q,
   input  wire        boost_gate_q,
   // modelled gate and pulse count
   output reg         gate_on,
   output reg  [15:0] pulse_cnt
);
   timeunit 1ns;
   timeprecision 100ps;
   always @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         gate_on <= 1'b0;
         pulse_cnt <= 16'h0000;
      end
      else
      begin
         gate_on <= boost_gate_q && !gate_off_q;
         if (boost_gate_q && !gate_off_q && !gate_on)
            pulse_cnt <= pulse_cnt + 16'h0001;
      end
   end
endmodule // sdbt_gate_model

// *** test/tb_top.sv ***
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int T = 2;
   logic        clk, reset_n, psel, penable, pwrite, ana, dig, pready, pslverr, err;
   logic        gate_off_q, boost_gate_q, irq_q, gate_on;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [15:0] pulse_cnt, n0;
   int          n_errors, checked, cyc, t, thr, ex;
   sdbt_short_boost #(.TICK_CYCLES(T)) u_dut (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .short_analog_cmp(ana), .short_digital_cmp(dig), .gate_off_q(gate_off_q), .boost_gate_q(boost_gate_q),
      .irq_q(irq_q));
   sdbt_gate_model u_gate (.clk(clk), .reset_n(reset_n), .gate_off_q(gate_off_q), .boost_gate_q(boost_gate_q),
      .gate_on(gate_on), .pulse_cnt(pulse_cnt));
   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 60000)
      begin
         n_errors++;
         tally_and_finish;
      end
   end
   task automatic tally_and_finish;
      $display("checked %0d errors %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e)
      begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic pin(input int p, input logic v);
      if (p == 1)
         dig <= v;
      else
         ana <= v;
   endtask
   task automatic fault(input int p, input int c);
      thr = p ? T * (c == 0 ? 0 : c == 1 ? 10 : c == 2 ? 100 : 1000) : (c == 0 ? 0 : c == 1 ? 40 : c == 2 ? 100 : 200);
      apb(1'b1, 8'h00, p ? c : c << 3);
      if (thr > 0)
      begin
         pin(p, 1'b1);
         repeat (thr / 2 + $urandom % (thr / 4)) @(posedge clk);
         pin(p, 1'b0);
         repeat (8) @(posedge clk);
         chk("gate_off after glitch", 0, gate_off_q);
      end
      pin(p, 1'b1);
      t = 0;
      while (gate_off_q !== 1'b1 && t < thr + 60)
      begin
         @(posedge clk);
         t++;
      end
      chk("fault delay in range", 1, t >= thr && t <= thr + T + 8);
      chk("model gate", 0, gate_on);
      apb(1'b0, 8'h04, 0);
      chk("status fault bit", 1 << p, rd);
      chk("irq on fault", 1, irq_q);
      apb(1'b0, 8'h0C, 0);
      chk("state during fault", 4 | (1 << p), rd);
      pin(p, 1'b0);
      repeat (8) @(posedge clk);
      apb(1'b1, 8'h04, 1 << p);
      @(posedge clk);
      chk("gate_off cleared", 0, gate_off_q);
      chk("irq cleared", 0, irq_q);
      $display("fault path %0d code %0d done", p, c);
   endtask
   task automatic boost(input logic w, input logic [1:0] d);
      ex = T * ((w ? 1000 : 100) * 100 / (d == 0 ? 2 : d == 1 ? 5 : d == 2 ? 10 : 20));
      n0 = pulse_cnt;
      apb(1'b1, 8'h00, 32'h100 | (d << 6) | (w << 5));
      t = 0;
      while (irq_q !== 1'b1 && t < ex + 60)
      begin
         @(posedge clk);
         t++;
      end
      chk("boost period", 1, t >= ex - T - 2 && t <= ex + T + 6);
      repeat (4) @(posedge clk);
      chk("boost pulses", 1, pulse_cnt - n0 == 2);
      apb(1'b1, 8'h00, 0);
      apb(1'b1, 8'h04, 4);
      $display("boost width %0d duty %0d done", w, d);
   endtask
   initial
   begin
      {reset_n, psel, penable, pwrite, ana, dig, paddr, pwdata} = 0;
      {n_errors, checked, cyc} = 0;
      t = $urandom(32'hFD34);
      repeat (3) @(posedge clk);
      reset_n <= 1'b1;
      apb(1'b0, 8'h00, 0);
      chk("ctrl reset", 0, rd);
      apb(1'b0, 8'h08, 0);
      chk("mask reset", 0, rd);
      apb(1'b1, 8'h10, 32'hFFFFFFFF);
      chk("unmapped write err", 1, err);
      apb(1'b0, 8'h10, 0);
      chk("unmapped read data", 0, rd);
      apb(1'b1, 8'h08, 7);
      apb(1'b0, 8'h08, 0);
      chk("mask readback", 7, rd);
      $display("register test done");
      for (int c = 0; c < 8; c++)
         fault(c / 4, c % 4);
      for (int d = 0; d < 4; d++)
         boost(1'b0, d);
      boost(1'b1, 2'h3);
      tally_and_finish;
   end
endmodule // tb_top
